// ---- design/usdb_top.sv ----
// Shadow receive/transmit buffer access path of a serial port with AXI4-Lite registers
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "usdb_regs.svh"

module usdb_top #(
    parameter int DEPTH = `USDB_FIFO_DEPTH
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        ser_in,
    input  wire logic        ir_in,
    output logic             ser_out,
    output logic             ir_out_n,
    output logic             irq
);
    // ******************************************************************
    // Bus slave
    // ******************************************************************
    logic        aw_full_q;
    logic [31:0] aw_addr_q;
    logic        w_full_q;
    logic [31:0] w_data_q;
    logic        w_byte0_q;
    logic        wr_fire;
    logic        rd_fire;
    logic        wr_shadow;
    logic        rd_shadow;
    logic        wr_hit;
    logic        rd_hit;
    logic [31:0] rd_val;

    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire       = aw_full_q && w_full_q && !s_axi_bvalid;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;

    // Any of the sixteen aligned words decodes to the one buffer
    assign wr_shadow = ((aw_addr_q - `USDB_SHADOW_BASE) < 32'h40) && (aw_addr_q[1:0] == 2'h0);
    assign rd_shadow = ((s_axi_araddr - `USDB_SHADOW_BASE) < 32'h40) && (s_axi_araddr[1:0] == 2'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= 32'h00000000;
            w_full_q  <= 1'b0;
            w_data_q  <= 32'h00000000;
            w_byte0_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q  <= 1'b1;
                w_data_q  <= s_axi_wdata;
                w_byte0_q <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `USDB_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `USDB_RESP_OKAY : `USDB_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `USDB_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_hit ? `USDB_RESP_OKAY : `USDB_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ******************************************************************
    // Control registers
    // ******************************************************************
    logic        fifo_en_q;
    logic        ir_mode_q;
    logic [15:0] baud_div_q;
    logic [2:0]  int_en_q;
    logic [2:0]  int_stat_q;
    logic        fifo_flush;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fifo_en_q  <= 1'b0;
            ir_mode_q  <= 1'b0;
            baud_div_q <= `USDB_BAUD_RESET;
            int_en_q   <= 3'h0;
        end else if (wr_fire) begin
            if (aw_addr_q == `USDB_CTRL_ADDR) begin
                fifo_en_q <= w_data_q[`USDB_CTRL_FIFO_EN];
                ir_mode_q <= w_data_q[`USDB_CTRL_IR_MODE];
            end
            if (aw_addr_q == `USDB_INT_EN_ADDR) begin
                int_en_q <= w_data_q[2:0];
            end
            if (aw_addr_q == `USDB_BAUD_ADDR && w_data_q[15:0] != 16'h0000) begin
                baud_div_q <= w_data_q[15:0];
            end
        end
    end

    // Switching FIFO mode empties both FIFOs so no stale byte mixes modes
    assign fifo_flush = wr_fire && (aw_addr_q == `USDB_CTRL_ADDR)
                        && (w_data_q[`USDB_CTRL_FIFO_EN] != fifo_en_q);

    // ******************************************************************
    // Receive buffer
    // ******************************************************************
    logic       rx_done;
    logic [7:0] rx_byte;
    logic [7:0] rx_hold_q;
    logic       rx_avail_q;
    logic       rx_oe_q;
    logic       rxf_ready;
    logic       rxf_valid;
    logic [7:0] rxf_data;
    logic       rx_pop;
    logic       data_ready;
    logic       oe_event;

    assign rx_pop     = rd_fire && rd_shadow;
    assign data_ready = fifo_en_q ? rxf_valid : rx_avail_q;
    assign oe_event   = rx_done && (fifo_en_q ? !rxf_ready : rx_avail_q);

    usdb_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_rx_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .flush     (fifo_flush),
        .in_valid  (rx_done && fifo_en_q),
        .in_ready  (rxf_ready),
        .in_data   (rx_byte),
        .out_valid (rxf_valid),
        .out_ready (rx_pop && fifo_en_q),
        .out_data  (rxf_data)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_hold_q  <= 8'h00;
            rx_avail_q <= 1'b0;
        end else if (rx_done && !fifo_en_q) begin
            rx_hold_q  <= rx_byte;
            rx_avail_q <= 1'b1;
        end else if (rx_pop || fifo_flush) begin
            rx_avail_q <= 1'b0;
        end
    end

    // Overrun sticks until the line status is read; a new overrun wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_oe_q <= 1'b0;
        end else if (oe_event) begin
            rx_oe_q <= 1'b1;
        end else if (rd_fire && s_axi_araddr == `USDB_STATUS_ADDR) begin
            rx_oe_q <= 1'b0;
        end
    end

    // ******************************************************************
    // Transmit buffer
    // ******************************************************************
    logic [7:0] tx_hold_q;
    logic       tx_full_q;
    logic       txf_ready;
    logic       txf_valid;
    logic [7:0] txf_data;
    logic       tx_take;
    logic       tx_wr;
    logic       tx_empty;
    logic       tx_busy;

    assign tx_wr = wr_fire && wr_shadow && w_byte0_q;
    assign tx_empty = fifo_en_q ? !txf_valid : !tx_full_q;

    usdb_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_tx_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .flush     (fifo_flush),
        .in_valid  (tx_wr && fifo_en_q),
        .in_ready  (txf_ready),
        .in_data   (w_data_q[7:0]),
        .out_valid (txf_valid),
        .out_ready (tx_take && fifo_en_q),
        .out_data  (txf_data)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_hold_q <= 8'h00;
            tx_full_q <= 1'b0;
        end else if (tx_wr && !fifo_en_q) begin
            tx_hold_q <= w_data_q[7:0];
            tx_full_q <= 1'b1;
        end else if (tx_take || fifo_flush) begin
            tx_full_q <= 1'b0;
        end
    end

    // ******************************************************************
    // Register read mux and interrupts
    // ******************************************************************
    logic [2:0] int_set;

    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h00000000;
        if (rd_shadow) begin
            rd_val[7:0] = fifo_en_q ? rxf_data : rx_hold_q;
        end else if (s_axi_araddr == `USDB_CTRL_ADDR) begin
            rd_val[`USDB_CTRL_FIFO_EN] = fifo_en_q;
            rd_val[`USDB_CTRL_IR_MODE] = ir_mode_q;
        end else if (s_axi_araddr == `USDB_STATUS_ADDR) begin
            rd_val[`USDB_STATUS_RXVAL]   = data_ready;
            rd_val[`USDB_STATUS_OE]      = rx_oe_q;
            rd_val[`USDB_STATUS_TXEMPTY] = tx_empty;
            rd_val[`USDB_STATUS_TXIDLE]  = tx_empty && !tx_busy;
        end else if (s_axi_araddr == `USDB_INT_STAT_ADDR) begin
            rd_val[2:0] = int_stat_q;
        end else if (s_axi_araddr == `USDB_INT_EN_ADDR) begin
            rd_val[2:0] = int_en_q;
        end else if (s_axi_araddr == `USDB_BAUD_ADDR) begin
            rd_val[15:0] = baud_div_q;
        end else if (s_axi_araddr != `USDB_INT_CLR_ADDR) begin
            rd_hit = 1'b0;
        end
    end

    assign wr_hit = wr_shadow || aw_addr_q == `USDB_CTRL_ADDR || aw_addr_q == `USDB_STATUS_ADDR
                    || aw_addr_q == `USDB_INT_STAT_ADDR || aw_addr_q == `USDB_INT_EN_ADDR
                    || aw_addr_q == `USDB_INT_CLR_ADDR || aw_addr_q == `USDB_BAUD_ADDR;

    assign int_set[`USDB_INT_RX]   = rx_done && !oe_event;
    assign int_set[`USDB_INT_OE]   = oe_event;
    assign int_set[`USDB_INT_TXEMPTY] = tx_take;

    // Write-one-to-clear; a set in the same cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_stat_q <= 3'h0;
        end else if (wr_fire && aw_addr_q == `USDB_INT_CLR_ADDR) begin
            int_stat_q <= (int_stat_q & ~w_data_q[2:0]) | int_set;
        end else begin
            int_stat_q <= int_stat_q | int_set;
        end
    end

    assign irq = |(int_stat_q & int_en_q);

    // ******************************************************************
    // Serial engines at sixteen ticks per bit
    // ******************************************************************
    logic                     ser_sync;
    logic                     ir_sync;
    logic                     rx_low;
    logic [15:0]              baud_cnt_q;
    logic                     tick;
    usdb_pkg::usdb_ser_state_t rx_st_q;
    logic [3:0]               rx_os_q;
    logic [2:0]               rx_bit_q;
    logic [7:0]               rx_sh_q;
    logic                     rx_mid_q;
    logic                     rx_zero_q;
    logic                     rx_val;
    usdb_pkg::usdb_ser_state_t tx_st_q;
    logic [3:0]               tx_os_q;
    logic [2:0]               tx_bit_q;
    logic [7:0]               tx_sh_q;
    logic                     tx_level;

    usdb_sync #(.RESET_VAL(1'b1)) u_ser_sync (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .pin_in    (ser_in),
        .level_out (ser_sync)
    );
    usdb_sync #(.RESET_VAL(1'b0)) u_ir_sync (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .pin_in    (ir_in),
        .level_out (ir_sync)
    );

    // Infrared input pulses high for a zero bit
    assign rx_low = ir_mode_q ? ir_sync : !ser_sync;
    assign tick   = (baud_cnt_q == 16'h0000);

    always_ff @(posedge aclk) begin
        if (!aresetn || tick) begin
            baud_cnt_q <= baud_div_q - 16'h0001;
        end else begin
            baud_cnt_q <= baud_cnt_q - 16'h0001;
        end
    end

    // Serial samples mid-bit; infrared catches a short pulse anywhere in the bit
    assign rx_val  = ir_mode_q ? !(rx_zero_q || rx_low) : rx_mid_q;
    assign rx_done = tick && rx_st_q == usdb_pkg::SER_STOP && rx_os_q == 4'hf && rx_val;
    assign rx_byte = rx_sh_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_st_q   <= usdb_pkg::SER_IDLE;
            rx_os_q   <= 4'h0;
            rx_bit_q  <= 3'h0;
            rx_sh_q   <= 8'h00;
            rx_mid_q  <= 1'b1;
            rx_zero_q <= 1'b0;
        end else if (tick) begin
            rx_os_q   <= rx_os_q + 4'h1;
            rx_zero_q <= (rx_os_q == 4'hf) ? 1'b0 : (rx_zero_q || rx_low);
            if (rx_os_q == 4'h7) begin
                rx_mid_q <= !rx_low;
            end
            case (rx_st_q)
                usdb_pkg::SER_IDLE: begin
                    rx_os_q   <= 4'h1;
                    rx_zero_q <= rx_low;
                    if (rx_low) begin
                        rx_st_q <= usdb_pkg::SER_START;
                    end
                end
                usdb_pkg::SER_START: begin
                    if (rx_os_q == 4'hf) begin
                        rx_st_q  <= rx_val ? usdb_pkg::SER_IDLE : usdb_pkg::SER_DATA;
                        rx_bit_q <= 3'h0;
                    end
                end
                usdb_pkg::SER_DATA: begin
                    if (rx_os_q == 4'hf) begin
                        rx_sh_q  <= {rx_val, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == 3'h7) begin
                            rx_st_q <= usdb_pkg::SER_STOP;
                        end
                    end
                end
                default: begin
                    if (rx_os_q == 4'hf) begin
                        rx_st_q <= usdb_pkg::SER_IDLE;
                    end
                end
            endcase
        end
    end

    assign tx_busy = (tx_st_q != usdb_pkg::SER_IDLE);
    assign tx_take = tick && !tx_busy && (fifo_en_q ? txf_valid : tx_full_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_st_q  <= usdb_pkg::SER_IDLE;
            tx_os_q  <= 4'h0;
            tx_bit_q <= 3'h0;
            tx_sh_q  <= 8'h00;
            tx_level <= 1'b1;
        end else if (tick) begin
            tx_os_q <= tx_os_q + 4'h1;
            case (tx_st_q)
                usdb_pkg::SER_IDLE: begin
                    tx_os_q  <= 4'h0;
                    tx_level <= 1'b1;
                    if (tx_take) begin
                        tx_sh_q  <= fifo_en_q ? txf_data : tx_hold_q;
                        tx_level <= 1'b0;
                        tx_st_q  <= usdb_pkg::SER_START;
                    end
                end
                usdb_pkg::SER_START: begin
                    if (tx_os_q == 4'hf) begin
                        tx_level <= tx_sh_q[0];
                        tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                        tx_bit_q <= 3'h0;
                        tx_st_q  <= usdb_pkg::SER_DATA;
                    end
                end
                usdb_pkg::SER_DATA: begin
                    if (tx_os_q == 4'hf) begin
                        tx_bit_q <= tx_bit_q + 3'h1;
                        tx_level <= (tx_bit_q == 3'h7) ? 1'b1 : tx_sh_q[0];
                        tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                        if (tx_bit_q == 3'h7) begin
                            tx_st_q <= usdb_pkg::SER_STOP;
                        end
                    end
                end
                default: begin
                    if (tx_os_q == 4'hf) begin
                        tx_st_q <= usdb_pkg::SER_IDLE;
                    end
                end
            endcase
        end
    end

    // Infrared sends a short low pulse at the start of each zero bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ser_out  <= 1'b1;
            ir_out_n <= 1'b1;
        end else begin
            ser_out  <= ir_mode_q ? 1'b1 : tx_level;
            ir_out_n <= !(ir_mode_q && tx_busy && !tx_level && tx_os_q < 4'(`USDB_IR_PULSE));
        end
    end
endmodule

// ---- design/usdb_regs.svh ----
// Register map, field positions and timing counts of the shadow buffer block
`ifndef USDB_REGS_SVH
`define USDB_REGS_SVH

`define USDB_SHADOW_BASE   32'h50001130
`define USDB_SHADOW_2      32'h50001138
`define USDB_SHADOW_WORDS  16
`define USDB_CTRL_ADDR     32'h50001200
`define USDB_STATUS_ADDR   32'h50001204
`define USDB_INT_STAT_ADDR 32'h50001208
`define USDB_INT_EN_ADDR   32'h5000120c
`define USDB_INT_CLR_ADDR  32'h50001210
`define USDB_BAUD_ADDR     32'h50001214

`define USDB_CTRL_FIFO_EN  0
`define USDB_CTRL_IR_MODE  1
`define USDB_STATUS_RXVAL   0
`define USDB_STATUS_OE      1
`define USDB_STATUS_TXEMPTY 5
`define USDB_STATUS_TXIDLE  6
`define USDB_INT_RX         0
`define USDB_INT_OE         1
`define USDB_INT_TXEMPTY    2

`define USDB_FIFO_DEPTH    16
`define USDB_OVERSAMPLE    16
`define USDB_IR_PULSE      3
`define USDB_BAUD_RESET    16'h0001
`define USDB_RESP_OKAY     2'h0
`define USDB_RESP_SLVERR   2'h2

`endif

// ---- design/usdb_pkg.sv ----
// Types shared by the shadow buffer block
package usdb_pkg;
    typedef enum logic [1:0] {
        SER_IDLE,
        SER_START,
        SER_DATA,
        SER_STOP
    } usdb_ser_state_t;
endpackage

// ---- design/usdb_sync.sv ----
// Two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module usdb_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin_in,
    output logic      level_out
);
    logic meta_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q    <= RESET_VAL;
            level_out <= RESET_VAL;
        end else begin
            meta_q    <= pin_in;
            level_out <= meta_q;
        end
    end
endmodule

// ---- design/usdb_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides and a flush
`timescale 1ns/1ps
module usdb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge aclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// ---- bench/usdb_properties.sv ----
// Port checker for the shadow buffer block, bound into the top
`timescale 1ns/1ps
`include "usdb_regs.svh"
module usdb_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        ser_out,
    input wire logic        ir_out_n
);
    // ****************
    // Bus and line checks
    // ****************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rd_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    chk_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    // Buffer reads are one byte wide; the rate register is sixteen bits
    chk_rd_byte: assert property (s_axi_arvalid && s_axi_arready
        && (s_axi_araddr - `USDB_SHADOW_BASE) < 32'h40 |=> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    chk_wr_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    chk_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    chk_ir_pulse: assert property ($fell(ir_out_n) |-> !ir_out_n[*3] ##1 ir_out_n)
        else $error("infrared pulse length wrong");
    // Sixteen cycles is the shortest start bit, at a rate register of one
    chk_ser_start: assert property ($fell(ser_out) |-> !ser_out[*8] ##1 !ser_out[*8])
        else $error("start bit too short");
endmodule
bind usdb_top usdb_chk usdb_chk_inst (.*);

// ---- bench/usdb_line_model.sv ----
// Remote serial transceiver and infrared sender on the far end of the line
`timescale 1ns/1ps
module usdb_line_model (
    input  wire logic aclk,
    input  wire logic ser_out,
    output logic      ser_in,
    output logic      ir_in
);
    // ****************
    // Frames, 16 cycles a bit
    // ****************
    logic [7:0] rx_q[$];
    logic [7:0] sh;
    initial begin
        ser_in = 1'b1;
        ir_in = 1'b0;
    end
    // Last frame bit is an idle gap so the byte lands before return
    task automatic send(input logic [7:0] b, input logic ir);
        logic [10:0] f;
        f = {2'b11, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge aclk);
            if (ir) ir_in <= !f[i];
            else ser_in <= f[i];
            repeat (3) @(posedge aclk);
            if (ir) ir_in <= 1'b0;
            repeat (12) @(posedge aclk);
        end
    endtask
    always begin
        @(negedge ser_out);
        repeat (8) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge aclk);
            sh[i] = ser_out;
        end
        rx_q.push_back(sh);
        repeat (16) @(posedge aclk);
    end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the shadow buffer block
`timescale 1ns/1ps
`include "usdb_regs.svh"
module tb_top;
    localparam int DEPTH = 4;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r, b;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        ser_in, ir_in, ser_out, ir_out_n, irq;
    int          error_cnt = 0;
    int          n_compared = 0;
    always #2 aclk = ~aclk;
    usdb_top #(.DEPTH(DEPTH)) usdb_top_inst (.*);
    usdb_line_model usdb_line_model_inst (.*);
    // ****************
    // Bus tasks and compares
    // ****************
    task automatic report_and_stop;
        if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tmo(input bit hit);
        if (hit) begin
            chk("timeout", 32'h0, 32'h1);
            report_and_stop;
        end
    endtask
    task automatic wr(input logic [31:0] a, d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 99; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        tmo(n == 99);
        b = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, e);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 99; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        tmo(n == 99);
        r = s_axi_rresp;
        chk("rdata", e, s_axi_rdata);
        s_axi_rready <= 1'b0;
    endtask
    task automatic lx(input logic [7:0] e);
        int n;
        for (n = 0; n < 999 && usdb_line_model_inst.rx_q.size() == 0; n++) @(posedge aclk);
        tmo(n == 999);
        chk("line", {24'h0, e}, {24'h0, usdb_line_model_inst.rx_q.pop_front()});
    endtask
    // ****************
    // Scenarios
    // ****************
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`USDB_STATUS_ADDR, 32'h60);
        rd(`USDB_SHADOW_2, 32'h0);
        wr(`USDB_INT_EN_ADDR, 32'h1);
        chk("bresp", {30'h0, `USDB_RESP_OKAY}, {30'h0, b});
        usdb_line_model_inst.send(8'h11, 1'b0);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`USDB_INT_EN_ADDR, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        usdb_line_model_inst.send(8'h22, 1'b0);
        rd(`USDB_STATUS_ADDR, 32'h63);
        rd(`USDB_SHADOW_BASE + 32'h3c, 32'h22);
        rd(`USDB_STATUS_ADDR, 32'h60);
        wr(`USDB_INT_EN_ADDR, 32'h1);
        wr(`USDB_INT_CLR_ADDR, 32'h7);
        chk("irq", 32'h0, {31'h0, irq});
        wr(`USDB_CTRL_ADDR, 32'h2);
        usdb_line_model_inst.send(8'h5a, 1'b1);
        rd(`USDB_SHADOW_BASE, 32'h5a);
        wr(`USDB_SHADOW_2, 32'h96);
        // Ten bits of sixteen cycles drain before the mode changes
        repeat (170) @(posedge aclk);
        wr(`USDB_CTRL_ADDR, 32'h0);
        wr(`USDB_SHADOW_2, 32'ha1);
        wr(`USDB_SHADOW_BASE + 32'h4, 32'hb2);
        rd(`USDB_STATUS_ADDR, 32'h0);
        wr(`USDB_SHADOW_BASE + 32'h8, 32'hc3);
        lx(8'ha1);
        lx(8'hc3);
        wr(`USDB_CTRL_ADDR, 32'h1);
        for (int i = 0; i <= DEPTH; i++) usdb_line_model_inst.send(8'(i + 8'h40), 1'b0);
        rd(`USDB_STATUS_ADDR, 32'h63);
        for (int i = 0; i < DEPTH; i++) rd(`USDB_SHADOW_BASE + 32'(4 * i), 32'(i + 8'h40));
        rd(`USDB_STATUS_ADDR, 32'h60);
        for (int i = 0; i < DEPTH + 2; i++) wr(`USDB_SHADOW_2, 32'(i + 8'h80));
        for (int i = 0; i <= DEPTH; i++) lx(8'(i + 8'h80));
        repeat (200) @(posedge aclk);
        chk("extra", 32'h0, 32'(usdb_line_model_inst.rx_q.size()));
        rd(32'h50001300, 32'h0);
        chk("rresp", {30'h0, `USDB_RESP_SLVERR}, {30'h0, r});
        wr(32'h50001300, 32'h0);
        chk("bresp", {30'h0, `USDB_RESP_SLVERR}, {30'h0, b});
        report_and_stop;
    end
endmodule
